// ---- src/vdc_pkg.sv ----
package vdc_pkg;

  // register map
  localparam logic [7:0] VDC_ADDR_DATAPATH_CFG = 8'h22;
  localparam logic [7:0] VDC_ADDR_RX_MODE_STATUS = 8'h23;
  localparam logic [7:0] VDC_RESET_DATAPATH_CFG = 8'h00;
  localparam logic [7:0] VDC_READ_UNMAPPED = 8'h00;
  localparam logic [7:0] VDC_RESERVED_ZERO = 8'h00;

  // field positions of the datapath configuration and receive-mode status registers
  localparam int VDC_BIT_FOUR_CH_EN = 0;
  localparam int VDC_BIT_AUDIO_TRANSPORT = 1;
  localparam int VDC_BIT_COLOUR_18 = 2;
  localparam int VDC_BIT_FOUR_CH_OVR = 3;
  localparam int VDC_BIT_AUDIO_ON_VIDEO_SUPPRESS = 4;
  localparam int VDC_BIT_PIXEL_VALID_POLARITY = 5;
  localparam int VDC_BIT_UNGATED_PIXEL_PASS = 6;
  localparam int VDC_BIT_FORWARD_LOAD_BLOCK = 7;
  localparam int VDC_BIT_RXS_RESERVED = 7;
  localparam int VDC_BIT_RXS_REPEATER = 2;

  // mask of the fields the forward channel may load
  localparam logic [7:0] VDC_FWD_LOAD_MASK = 8'h7f;

  // video widths selected by the colour-depth field
  localparam logic [4:0] VDC_WIDTH_18 = 5'h12;
  localparam logic [4:0] VDC_WIDTH_24 = 5'h18;

  // 18-bit video keeps the upper six bits of each colour
  localparam logic [23:0] VDC_MASK_18 = 24'hfcfcfc;

  // decoded datapath controls
  typedef struct packed {
    logic pixel_valid_active_low;
    logic ungated_pixel_pass;
    logic content_protect_enable;
    logic audio_on_video_enable;
    logic four_channel_enable;
    logic in_band_transport;
    logic colour_18_bit;
    logic surround_allowed;
  } vdc_ctrl_type;

endpackage

// ---- src/vdc_decode.sv ----
`timescale 1ns/1ns
// turns the stored register byte into datapath controls
module vdc_decode (
  input wire logic [7:0] cfg,
  input wire logic repeater_mode,
  input wire logic compat_mode,
  output vdc_pkg::vdc_ctrl_type ctrl
);

  wire logic ungated;
  wire logic four_ch;

  // ungated pass is ignored in backward-compatibility mode; gated path works there
  assign ungated = cfg[vdc_pkg::VDC_BIT_UNGATED_PIXEL_PASS] & ~compat_mode;
  // override set: enable follows bit 0; clear: four-channel off
  assign four_ch = cfg[vdc_pkg::VDC_BIT_FOUR_CH_OVR] & cfg[vdc_pkg::VDC_BIT_FOUR_CH_EN];

  // field decode
  assign ctrl.pixel_valid_active_low = cfg[vdc_pkg::VDC_BIT_PIXEL_VALID_POLARITY];
  assign ctrl.ungated_pixel_pass = ungated;
  assign ctrl.content_protect_enable = ~ungated;
  assign ctrl.audio_on_video_enable = ~ungated &
    ~cfg[vdc_pkg::VDC_BIT_AUDIO_ON_VIDEO_SUPPRESS];
  assign ctrl.four_channel_enable = four_ch;
  assign ctrl.in_band_transport = cfg[vdc_pkg::VDC_BIT_AUDIO_TRANSPORT];
  assign ctrl.colour_18_bit = cfg[vdc_pkg::VDC_BIT_COLOUR_18];
  // surround audio unsupported in repeater with 18-bit video
  assign ctrl.surround_allowed = ~(repeater_mode & cfg[vdc_pkg::VDC_BIT_COLOUR_18]);

endmodule // vdc_decode

// ---- src/vdc_datapath_config.sv ----
// Functional notes
// - block bit set stops forward-channel loading and keeps local writes
// - lower seven fields load from remote serializer unless block bit set
// - ungated pass forwards rgb regardless of pixel-valid
// - ungated pass disables content protection and blocks packetized audio
// - backward-compatibility mode works with ungated pass cleared
// - polarity 1 is active low idle high, 0 active high idle low
// - suppress bit 1 keeps packetized audio off rgb pins, 0 outputs it
// - four-channel override set takes enable from bit 0, else disabled
// - colour select 1 is 18-bit video, 0 is 24-bit
// - repeater with 18-bit video gives no surround audio
// - transport field picks in-band or data-island i2s transport
// - four-channel enable 1 turns on four-channel i2s when override set, 0 off
// - configuration at 0x22, resets to zero, read and write
// - receive-mode status bit 7 reserved, read-only, reads zero
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
module vdc_datapath_config (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic fwd_cfg_valid,
  input wire logic [7:0] fwd_cfg_data,
  input wire logic repeater_mode,
  input wire logic compat_mode,
  input wire logic pixel_valid_in,
  input wire logic [23:0] rgb_in,
  input wire logic [23:0] audio_pkt_in,
  input wire logic audio_pkt_valid,
  output logic [23:0] rgb_out,
  output logic rgb_out_valid,
  output vdc_pkg::vdc_ctrl_type ctrl_out,
  output logic [4:0] video_width
);

  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [7:0] rdata_nxt;
  vdc_pkg::vdc_ctrl_type ctrl;
  wire logic wr_cfg;
  wire logic rd_cfg;
  wire logic rd_rxs;
  wire logic fwd_load;
  wire logic pix_active;
  logic [7:0] rxs_view;
  logic [23:0] rgb_nxt;
  logic rgb_valid_nxt;

  // address decode
  assign wr_cfg = reg_wr & (reg_addr == vdc_pkg::VDC_ADDR_DATAPATH_CFG);
  assign rd_cfg = reg_addr == vdc_pkg::VDC_ADDR_DATAPATH_CFG;
  assign rd_rxs = reg_addr == vdc_pkg::VDC_ADDR_RX_MODE_STATUS;

  // forward load only when block bit clear; software write wins same cycle
  assign fwd_load = fwd_cfg_valid & ~cfg_r[vdc_pkg::VDC_BIT_FORWARD_LOAD_BLOCK];

  // next configuration value
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_cfg) begin
      cfg_nxt = reg_wdata;
    end else if (fwd_load) begin
      // bit 7 is local-only, the remote never sets the block
      cfg_nxt = (cfg_r & ~vdc_pkg::VDC_FWD_LOAD_MASK) |
        (fwd_cfg_data & vdc_pkg::VDC_FWD_LOAD_MASK);
    end
  end

  // status view: only repeater strap shown, reserved bit 7 held at zero
  always_comb begin
    rxs_view = vdc_pkg::VDC_RESERVED_ZERO;
    rxs_view[vdc_pkg::VDC_BIT_RXS_REPEATER] = repeater_mode;
    rxs_view[vdc_pkg::VDC_BIT_RXS_RESERVED] = 1'b0;
  end

  // read mux, if-chain decode
  always_comb begin
    rdata_nxt = vdc_pkg::VDC_READ_UNMAPPED;
    if (!reg_rd) begin
      rdata_nxt = vdc_pkg::VDC_READ_UNMAPPED;
    end else if (rd_cfg) begin
      rdata_nxt = cfg_r;
    end else if (rd_rxs) begin
      rdata_nxt = rxs_view;
    end
  end

  vdc_decode u_decode (
    .cfg(cfg_r),
    .repeater_mode(repeater_mode),
    .compat_mode(compat_mode),
    .ctrl(ctrl)
  );

  // pixel-valid sense follows polarity field
  assign pix_active = pixel_valid_in ^ ctrl.pixel_valid_active_low;

  // rgb pin mux: video when valid or ungated, else packetized audio if allowed
  always_comb begin
    rgb_nxt = rgb_in;
    rgb_valid_nxt = 1'b0;
    if (pix_active || ctrl.ungated_pixel_pass) begin
      rgb_nxt = rgb_in;
      rgb_valid_nxt = 1'b1;
    end else if (audio_pkt_valid && ctrl.audio_on_video_enable) begin
      rgb_nxt = audio_pkt_in;
      rgb_valid_nxt = 1'b0;
    end
    // 18-bit mode leaves the two low bits of each colour unused
    if (ctrl.colour_18_bit) begin
      rgb_nxt = rgb_nxt & vdc_pkg::VDC_MASK_18;
    end
  end

  // register state, cleared by reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= vdc_pkg::VDC_RESET_DATAPATH_CFG;
      reg_rdata <= vdc_pkg::VDC_READ_UNMAPPED;
    end else begin
      cfg_r <= cfg_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // registered datapath outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rgb_out <= '0;
      rgb_out_valid <= 1'b0;
      ctrl_out <= '0;
      video_width <= vdc_pkg::VDC_WIDTH_24;
    end else begin
      rgb_out <= rgb_nxt;
      rgb_out_valid <= rgb_valid_nxt;
      ctrl_out <= ctrl;
      video_width <= ctrl.colour_18_bit ? vdc_pkg::VDC_WIDTH_18 : vdc_pkg::VDC_WIDTH_24;
    end
  end

endmodule // vdc_datapath_config

// ---- dv/vdc_fwd_model.sv ----
`timescale 1ns/1ns
// remote serializer: one config byte per send request
module vdc_fwd_model (
  input wire logic sys_clk,
  input wire logic send,
  input wire logic [7:0] b_in,
  output logic fwd_cfg_valid,
  output logic [7:0] fwd_cfg_data
);
  initial {fwd_cfg_valid, fwd_cfg_data} = 9'h000;
  // data lines toggle between bytes so stale values never look valid
  always @(posedge sys_clk) begin
    fwd_cfg_valid <= send;
    fwd_cfg_data <= send ? b_in : ~fwd_cfg_data;
  end
endmodule // vdc_fwd_model

// ---- dv/vdc_datapath_config_properties.sv ----
`timescale 1ns/1ns
module vdc_datapath_config_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic fwd_cfg_valid,
  input wire logic [7:0] fwd_cfg_data,
  input wire logic repeater_mode,
  input wire logic compat_mode,
  input wire vdc_pkg::vdc_ctrl_type ctrl_out,
  input wire logic [4:0] video_width
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // bus answers, forward loads and decoded fields
  chk_rsvd_zero: assert property (reg_rd && reg_addr == 8'h23 |=> !reg_rdata[7])
    else $error("status bit 7 not zero");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_wr_rd: assert property (
    (reg_wr && reg_addr == 8'h22) ##1 (reg_rd && reg_addr == 8'h22)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("config read-back wrong");
  chk_block_hold: assert property (
    (reg_wr && reg_addr == 8'h22 && reg_wdata[7])
    ##1 (fwd_cfg_valid && !reg_wr) ##1 (reg_rd && reg_addr == 8'h22)
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("forward load not blocked");
  chk_fwd_load: assert property (
    (reg_wr && reg_addr == 8'h22 && !reg_wdata[7])
    ##1 (fwd_cfg_valid && !reg_wr) ##1 (reg_rd && reg_addr == 8'h22)
    |=> reg_rdata == {1'h0, $past(fwd_cfg_data[6:0], 2)}) else $error("forward load lost");
  chk_width_sel: assert property (
    (reg_wr && reg_addr == 8'h22) ##1 (!reg_wr && !fwd_cfg_valid)[*3]
    |-> video_width == ($past(reg_wdata[2], 3) ? 5'h12 : 5'h18))
    else $error("video width wrong");
  chk_field_decode: assert property (
    (reg_wr && reg_addr == 8'h22) ##1 (!reg_wr && !fwd_cfg_valid)[*3]
    |-> ctrl_out.pixel_valid_active_low == $past(reg_wdata[5], 3)
    && ctrl_out.four_channel_enable == ($past(reg_wdata[3], 3) && $past(reg_wdata[0], 3))
    && ctrl_out.in_band_transport == $past(reg_wdata[1], 3)) else $error("decode wrong");
  // compat mode masks the ungated pass; strap sampled one edge before, written config three edges before
  chk_ungated_sel: assert property (
    (reg_wr && reg_addr == 8'h22) ##1 (!reg_wr && !fwd_cfg_valid)[*3]
    |-> ctrl_out.ungated_pixel_pass == ($past(reg_wdata[6], 3) && !$past(compat_mode)))
    else $error("ungated pass select wrong");
  chk_surround_off: assert property (
    (reg_wr && reg_addr == 8'h22) ##1 (!reg_wr && !fwd_cfg_valid)[*3]
    |-> ctrl_out.surround_allowed == !($past(repeater_mode) && $past(reg_wdata[2], 3)))
    else $error("surround permission wrong");
  chk_ungated_blocks: assert property (ctrl_out.ungated_pixel_pass
    |-> !ctrl_out.content_protect_enable && !ctrl_out.audio_on_video_enable)
    else $error("ungated pass left audio or protection on");
endmodule // vdc_datapath_config_properties
bind vdc_datapath_config vdc_datapath_config_properties u_chk (.*);

// ---- dv/vdc_datapath_config_tb.sv ----
`timescale 1ns/1ns
module vdc_datapath_config_tb;
  logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, send = 0, rep = 0, cm = 0, pv = 0, av = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, b_in = 0, reg_rdata, fwd_cfg_data, c;
  logic fwd_cfg_valid;
  logic [23:0] rgb = 0, aud = 0, rgb_out;
  logic [24:0] p;
  logic rgb_out_valid;
  logic [7:0] tbl [6] = '{8'h80, 8'h90, 8'hc0, 8'ha4, 8'hb0, 8'hc4};
  int errors = 0, n_compared = 0, cyc = 0;
  vdc_datapath_config u_vdc_datapath_config (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fwd_cfg_valid(fwd_cfg_valid), .fwd_cfg_data(fwd_cfg_data), .repeater_mode(rep),
    .compat_mode(cm), .pixel_valid_in(pv), .rgb_in(rgb), .audio_pkt_in(aud),
    .audio_pkt_valid(av), .rgb_out(rgb_out), .rgb_out_valid(rgb_out_valid), .ctrl_out(),
    .video_width());
  vdc_fwd_model u_vdc_fwd_model (.sys_clk(sys_clk), .send(send), .b_in(b_in),
    .fwd_cfg_valid(fwd_cfg_valid), .fwd_cfg_data(fwd_cfg_data));
  initial forever #20 sys_clk = ~sys_clk;
  // random video traffic, plus a hang limit well above the expected run
  always @(posedge sys_clk) begin
    {pv, av} <= 2'($urandom);
    rgb <= 24'($urandom);
    aud <= 24'($urandom);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [24:0] a, input logic [24:0] e);
    n_compared++;
    if (a !== e) begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, a, e);
    end
  endtask
  // one bus cycle; read data is settled when this returns
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'h0;
    #1;
  endtask
  // write, forward byte and read-back on consecutive edges
  task automatic wfr(input logic [7:0] w, input logic [7:0] f);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= 8'h22;
    reg_wdata <= w;
    send <= 1'h1;
    b_in <= f;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    send <= 1'h0;
    bus(0, 8'h22, 8'h00);
    chk(reg_rdata, w[7] ? w : {1'h0, f[6:0]});
  endtask
  // ungated pass wins, then idle audio unless suppressed; 18-bit drops low bits
  // valid flag on top; compat mode cancels the ungated pass, so audio may return
  function automatic logic [24:0] exp_rgb(input logic [7:0] k);
    logic u;
    logic [23:0] v;
    u = k[6] && !cm;
    v = ((pv ^ k[5]) || u) ? rgb : (av && !k[4] && !u) ? aud : rgb;
    return {(pv ^ k[5]) || u, k[2] ? v & 24'hfcfcfc : v};
  endfunction
  task automatic stop_test();
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(80));
    repeat (16) @(posedge sys_clk);
    rst <= 1'h0;
    bus(0, 8'h22, 8'h00);
    chk(reg_rdata, 24'h0);
    rep <= 1'h1;
    bus(1, 8'h23, 8'hff);
    bus(0, 8'h23, 8'h00);
    chk(reg_rdata, 24'h4);
    bus(0, 8'h40, 8'h00);
    chk(reg_rdata, 24'h0);
    repeat (40) begin
      c = 8'($urandom);
      bus(1, 8'h22, c);
      bus(0, 8'h22, 8'h00);
      chk(reg_rdata, {16'h0, c});
      wfr(8'($urandom), 8'($urandom));
    end
    foreach (tbl[i]) begin
      bus(1, 8'h22, tbl[i]);
      cm <= 1'($urandom);
      repeat (2) @(posedge sys_clk);
      #1 p = exp_rgb(tbl[i]);
      repeat (30) begin
        @(posedge sys_clk);
        #1 chk({rgb_out_valid, rgb_out}, p);
        p = exp_rgb(tbl[i]);
      end
    end
    // reset in mid-run must clear the last written configuration
    rst <= 1'h1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    bus(0, 8'h22, 8'h00);
    chk(reg_rdata, 25'h0);
    stop_test();
  end
endmodule // vdc_datapath_config_tb
